/* dv/hpb_host_model.sv */
// Host model: drives the port pins in either host style.
// Assumes ready_i and data_i come from the port, style_i from its strap.
`timescale 1ns/100ps
module hpb_host_model (
  input  wire logic          clk_i,
  input  wire logic          style_i,
  input  wire logic          ready_i,
  input  wire logic [7:0]    data_i,
  output hpb_pkg::hpb_pins_t pins_o
);
  import hpb_pkg::*;
  // ----------------------------------
  // Pin sequencing, 2 ns after an edge
  // ----------------------------------
  initial pins_o = PINS_IDLE;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  // Start a burst; address lines scrambled once taken
  task automatic latch(input hpb_addr_t a);
    pins_o.cs_n = 1'b0;
    pins_o.addr = a;
    pins_o.address_latch_strobe = !style_i;
    tick(2);
    pins_o.address_latch_strobe = style_i;
    tick(2);
    pins_o.addr = ~a;
  endtask : latch
  // One byte; waits at most 20 cycles for the answer
  task automatic xfer(input logic w, input hpb_data_t d, output hpb_data_t q);
    int   n;
    logic wr_a;
    n = 0;
    wr_a = w && !style_i;
    pins_o.data = d;
    pins_o.write_or_rw_n = !(w && style_i);
    tick(1);
    if (wr_a)
      pins_o.write_or_rw_n = 1'b0;
    else
      pins_o.read_or_data_strobe_n = 1'b0;
    tick(2);
    while (!wr_a && ready_i !== !style_i && n < 20)
    begin
      tick(1);
      n++;
    end
    q = (n < 20) ? data_i : 8'hxx;
    tick(1);
    pins_o.read_or_data_strobe_n = 1'b1;
    pins_o.write_or_rw_n = !(w && style_i);
    tick(1);
    pins_o.data = ~d; // Released bus must not look valid
    tick(1);
  endtask : xfer
  // Close the burst, then deselect
  task automatic end_burst();
    pins_o.address_latch_strobe = !style_i;
    tick(2);
    pins_o.cs_n = 1'b1;
    tick(1);
    pins_o.address_latch_strobe = 1'b0;
    tick(1);
  endtask : end_burst
endmodule : hpb_host_model

/* dv/hpb_host_port_bench.sv */
// Bench: random bursts in both host styles against a byte store.
// Assumes reset leaves the store alone; only written places are read.
`timescale 1ns/100ps
module hpb_host_port_bench;
  import hpb_pkg::*;
  logic        clk_i, rst_i, sel, oe_n, in_en, rdy, busy;
  logic [7:0]  dat;
  logic [10:0] lat;
  hpb_pins_t   pins;
  hpb_data_t   exp_mem [0:MEM_DEPTH-1];
  integer      seed = 32'h11a51dcd;
  int          n_errors = 0;
  int          num_checks = 0;
  hpb_host_port hpb_host_port_inst (.clk_i(clk_i), .rst_i(rst_i),
    .host_style_select_i(sel), .pins_i(pins), .data_o(dat), .data_oe_n_o(oe_n),
    .data_in_en_o(in_en), .ready_or_acknowledge_o(rdy), .burst_active_o(busy),
    .latched_addr_o(lat));
  hpb_host_model hpb_host_model_inst (.clk_i(clk_i), .style_i(sel), .ready_i(rdy),
    .data_i(dat), .pins_o(pins));
  // --------------------------
  // Clock, verdict and compare
  // --------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input hpb_addr_t e, input hpb_addr_t g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic do_reset(input logic st);
    rst_i = 1'b1;
    sel = st;
    repeat (12) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #2;
  endtask : do_reset
  // Burst of n bytes from a; writes update the expected store
  task automatic burst(input logic w, input hpb_addr_t a, input int n);
    hpb_data_t d, q;
    hpb_addr_t x;
    hpb_host_model_inst.latch(a);
    for (int i = 0; i < n; i++)
    begin
      x = hpb_addr_t'(a + i);
      d = hpb_data_t'($random(seed));
      if (w)
        exp_mem[x] = d;
      hpb_host_model_inst.xfer(w, d, q);
      chk("latched address", x, lat);
      chk("pads released", 11'h005, {8'h00, oe_n, in_en, rdy});
      if (!w)
        chk("read data", {3'h0, exp_mem[x]}, {3'h0, q});
    end
    hpb_host_model_inst.end_burst();
    chk("burst flag", 11'h000, {10'h000, busy});
    $display("burst done: write %0d start %h length %0d", w, a, n);
  endtask : burst
  // Writes then reads, wrapping at the top, in both styles
  initial
  begin
    hpb_addr_t a;
    do_reset(STYLE_A);
    a = hpb_addr_t'($random(seed));
    burst(1'b1, a, 6);
    burst(1'b1, 11'h7fe, 4);
    burst(1'b0, a, 6);
    burst(1'b0, 11'h7fe, 4);
    do_reset(STYLE_B);
    burst(1'b0, a, 6);
    burst(1'b1, 11'h7ff, 3);
    burst(1'b0, 11'h7ff, 3);
    end_sim();
  end
  // Watchdog: the run needs about 300 cycles
  initial
  begin
    #(25 * 5000);
    n_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    end_sim();
  end
endmodule : hpb_host_port_bench

/* dv/hpb_host_port_properties.sv */
// Checker bound to the burst host port's top ports.
// Assumes the style strap changes only while reset is held.
`timescale 1ns/100ps
module hpb_host_port_chk (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               host_style_select_i,
  input wire hpb_pkg::hpb_pins_t pins_i,
  input wire logic [7:0]         data_o,
  input wire logic               data_oe_n_o,
  input wire logic               data_in_en_o,
  input wire logic               ready_or_acknowledge_o,
  input wire logic               burst_active_o,
  input wire logic [10:0]        latched_addr_o
);
  import hpb_pkg::*;
  logic s, cs, ls, ds, wr, rdy;
  // Short aliases for the strap, the host pins and ready
  assign s = host_style_select_i;
  assign cs = !pins_i.cs_n;
  assign ls = pins_i.address_latch_strobe;
  assign ds = pins_i.read_or_data_strobe_n;
  assign wr = pins_i.write_or_rw_n;
  assign rdy = ready_or_acknowledge_o;
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_CAP_A: assert property (!s && cs && $fell(ls) |=>
    latched_addr_o == $past(pins_i.addr) && burst_active_o) else $error("capture a");
  AST_CAP_B: assert property (s && cs && $rose(ls) |=>
    latched_addr_o == $past(pins_i.addr) && burst_active_o) else $error("capture b");
  AST_END_A: assert property (!s && $rose(ls) |=> !burst_active_o)
    else $error("end a");
  AST_END_B: assert property (s && $fell(ls) |=> !burst_active_o)
    else $error("end b");
  // Between bursts the counter must not creep
  AST_HOLD: assert property (!burst_active_o && !$past(burst_active_o)
    |-> $stable(latched_addr_o)) else $error("address moved");
  AST_STEP: assert property (burst_active_o && $past(burst_active_o)
    && $changed(latched_addr_o) |-> latched_addr_o == $past(latched_addr_o) + 11'h001)
    else $error("bad step");
  AST_RDY_A: assert property (!s && cs && $fell(ds) && wr && rdy
    |=> !rdy ##[1:4] rdy) else $error("ready");
  AST_ACK_B: assert property (s && cs && $fell(ds) && rdy
    |=> rdy ##[1:4] !rdy) else $error("acknowledge");
  // Idle pads are the precondition, so a strobe inside an open cycle is skipped
  AST_OE_RD: assert property (cs && $fell(ds) && wr && data_oe_n_o && !data_in_en_o
    |=> !data_oe_n_o && !data_in_en_o) else $error("output drivers");
  AST_IN_EN_A: assert property (!s && cs && $fell(wr) && ds && data_oe_n_o && !data_in_en_o
    |=> data_in_en_o && data_oe_n_o) else $error("input path");
  AST_WR_END_A: assert property (!s && $rose(wr) && data_in_en_o |=> !data_in_en_o)
    else $error("write not closed");
endmodule : hpb_host_port_chk
bind hpb_host_port hpb_host_port_chk hpb_host_port_chk_inst (.clk_i, .rst_i,
  .host_style_select_i, .pins_i, .data_o, .data_oe_n_o, .data_in_en_o,
  .ready_or_acknowledge_o, .burst_active_o, .latched_addr_o);

/* rtl/hpb_host_port.sv */
// Burst-capable 8-bit host port with its own 2048-byte location store.
// Assumes host pins synchronous to clk_i and the style strap held static.
`timescale 1ns/100ps

// Overview of operation
// - Latch-enable style: rising latch strobe ends any active burst.
// - After a burst ends, no more address stepping; new access may start.
// - Latch-enable style: address captured on latch strobe fall with chip select low.
// - Write strobe low with read strobe high enables data input path.
// - Write strobe rise stores the data byte and ends the cycle.
// - Later burst writes: each write strobe fall steps address, enables input.
// - Each later burst write lands in the stepped location on strobe rise.
// - Address-strobe style: address captured on strobe rise with chip select low.
// - Direction high and data strobe low: drive addressed contents out.
// - Read acknowledge asserted once data stable; host raises data strobe.
// - Later burst reads: each data strobe fall steps address and drives it.
// - Each later burst read is acknowledged when data is stable.
// - Latch-enable reads: ready low at strobe fall, high when data stable.
module hpb_host_port (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               host_style_select_i,
  input  wire hpb_pkg::hpb_pins_t pins_i,
  output logic [7:0]              data_o,
  output logic                    data_oe_n_o,
  output logic                    data_in_en_o,
  output logic                    ready_or_acknowledge_o,
  output logic                    burst_active_o,
  output logic [10:0]             latched_addr_o
);
  import hpb_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  // Pin history and registered strap
  hpb_pins_t prev_reg;
  logic      style_reg;

  // Burst address tracking
  hpb_addr_t addr_reg,      addr_next;
  logic      burst_reg,     burst_next;
  logic      first_reg,     first_next;

  // Cycle progress and pad controls
  hpb_acc_t  acc_reg,       acc_next;
  logic      is_read_reg,   is_read_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  hpb_data_t dout_reg,      dout_next;
  logic      oe_n_reg,      oe_n_next;
  logic      in_en_reg,     in_en_next;
  logic      rdy_reg,       rdy_next;

  // Store write port and the store itself
  logic      mem_we;
  hpb_addr_t mem_waddr;
  hpb_data_t mem_wdata;
  hpb_data_t mem [MEM_DEPTH];

  // Decoded pin edges valid for one cycle, and the chip select level
  logic als_rise;
  logic als_fall;
  logic rds_fall;
  logic rds_rise;
  logic wrs_fall;
  logic wrs_rise;
  logic sel;
  logic strobe_fall;
  logic strobe_rise;
  logic strobe_is_read;

  // ----------------------------------------------------------------
  // Edge detection on the host pins
  // ----------------------------------------------------------------
  // Pins are taken as synchronous, so one history stage suffices
  assign als_rise = pins_i.address_latch_strobe & ~prev_reg.address_latch_strobe;
  assign als_fall = ~pins_i.address_latch_strobe & prev_reg.address_latch_strobe;
  assign rds_fall = ~pins_i.read_or_data_strobe_n & prev_reg.read_or_data_strobe_n;
  assign rds_rise = pins_i.read_or_data_strobe_n & ~prev_reg.read_or_data_strobe_n;
  assign wrs_fall = ~pins_i.write_or_rw_n & prev_reg.write_or_rw_n;
  assign wrs_rise = pins_i.write_or_rw_n & ~prev_reg.write_or_rw_n;
  assign sel      = ~pins_i.cs_n;

  // Style-dependent meaning of the cycle strobes
  always_comb
  begin
    if (style_reg == STYLE_B)
    begin
      // One data strobe, direction from the read-not-write pin
      strobe_fall    = rds_fall;
      strobe_rise    = rds_rise;
      strobe_is_read = pins_i.write_or_rw_n;
    end
    else
    begin
      // Separate strobes; a read needs write high and vice versa
      strobe_fall    = (rds_fall & pins_i.write_or_rw_n) |
                       (wrs_fall & pins_i.read_or_data_strobe_n);
      strobe_rise    = is_read_reg ? rds_rise : wrs_rise;
      strobe_is_read = rds_fall;
    end
  end

  // ----------------------------------------------------------------
  // Address latch and burst tracking
  // ----------------------------------------------------------------
  always_comb
  begin
    addr_next  = addr_reg;
    burst_next = burst_reg;
    first_next = first_reg;
    // One style ends on a rising latch strobe, the other on a fall
    if (style_reg == STYLE_A)
    begin
      if (als_rise)
      begin
        burst_next = 1'b0;
      end
      else if (als_fall && sel)
      begin
        addr_next  = pins_i.addr;
        burst_next = 1'b1;
        first_next = 1'b1;
      end
    end
    else
    begin
      if (als_fall)
      begin
        burst_next = 1'b0;
      end
      else if (als_rise && sel)
      begin
        addr_next  = pins_i.addr;
        burst_next = 1'b1;
        first_next = 1'b1;
      end
    end
    // Only strobes after the first access of a burst step the address
    if (sel && strobe_fall && acc_reg == ACC_IDLE)
    begin
      if (burst_reg && !first_reg)
      begin
        addr_next = addr_reg + ADDR_STEP;
      end
      first_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Data strobe cycle: drivers, settle count, ready/acknowledge
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_next     = acc_reg;
    is_read_next = is_read_reg;
    cnt_next     = cnt_reg;
    dout_next    = dout_reg;
    oe_n_next    = oe_n_reg;
    in_en_next   = in_en_reg;
    rdy_next     = rdy_reg;
    mem_we       = 1'b0;
    mem_waddr    = addr_reg;
    mem_wdata    = pins_i.data;
    // One cycle open at a time; strobe falls seen outside idle are dropped
    unique case (acc_reg)
      ACC_IDLE:
      begin
        if (sel && strobe_fall)
        begin
          acc_next     = ACC_SETTLE;
          is_read_next = strobe_is_read;
          cnt_next     = SETTLE_LOAD;
          if (strobe_is_read)
          begin
            oe_n_next = 1'b0;
          end
          else
          begin
            in_en_next = 1'b1;
          end
          // Latch-enable style drops ready at once on reads only; other style keeps ack idle
          rdy_next = (style_reg == STYLE_A) ? ~strobe_is_read : 1'b1;
        end
      end
      ACC_SETTLE:
      begin
        // Stepped address is already in addr_reg here
        dout_next = mem[addr_reg];
        if (strobe_rise)
        begin
          acc_next = ACC_HOLD;
        end
        else if (cnt_reg == CNT_ZERO)
        begin
          acc_next = ACC_HOLD;
          // Ready high / acknowledge low both mean data stable
          rdy_next = (style_reg == STYLE_A);
        end
        else
        begin
          cnt_next = cnt_reg - CNT_ONE;
        end
      end
      ACC_HOLD:
      begin
        if (is_read_reg)
        begin
          dout_next = mem[addr_reg];
        end
        // A deselect mid-cycle aborts it without a write
        if (strobe_rise || pins_i.cs_n)
        begin
          acc_next   = ACC_IDLE;
          oe_n_next  = 1'b1;
          in_en_next = 1'b0;
          rdy_next   = 1'b1;
          // Write lands on the rising strobe in the latched location
          mem_we     = ~is_read_reg & strobe_rise;
        end
      end
      default:
      begin
        acc_next = ACC_IDLE;
      end
    endcase
    // A strobe rise during settling still completes a write
    if (acc_reg == ACC_SETTLE && strobe_rise)
    begin
      acc_next   = ACC_IDLE;
      oe_n_next  = 1'b1;
      in_en_next = 1'b0;
      rdy_next   = 1'b1;
      mem_we     = ~is_read_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Strap sampled by clock; reset loads the latch-enable style STYLE_A
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_reg    <= PINS_IDLE;
      style_reg   <= STYLE_A;
      addr_reg    <= ADDR_RESET;
      burst_reg   <= 1'b0;
      first_reg   <= 1'b0;
      acc_reg     <= ACC_IDLE;
      is_read_reg <= 1'b0;
      cnt_reg     <= CNT_ZERO;
      dout_reg    <= DATA_RESET;
      oe_n_reg    <= 1'b1;
      in_en_reg   <= 1'b0;
      rdy_reg     <= 1'b1;
    end
    else
    begin
      prev_reg    <= pins_i;
      style_reg   <= host_style_select_i;
      addr_reg    <= addr_next;
      burst_reg   <= burst_next;
      first_reg   <= first_next;
      acc_reg     <= acc_next;
      is_read_reg <= is_read_next;
      cnt_reg     <= cnt_next;
      dout_reg    <= dout_next;
      oe_n_reg    <= oe_n_next;
      in_en_reg   <= in_en_next;
      rdy_reg     <= rdy_next;
    end
  end

  // Location store; no reset so it maps onto plain RAM
  always_ff @(posedge clk_i)
  begin
    if (mem_we)
    begin
      mem[mem_waddr] <= mem_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from registers so the pads see no decode glitches
  assign data_o                 = dout_reg;
  assign data_oe_n_o            = oe_n_reg;
  assign data_in_en_o           = in_en_reg;
  assign ready_or_acknowledge_o = rdy_reg;
  assign burst_active_o         = burst_reg;
  assign latched_addr_o         = addr_reg;

endmodule : hpb_host_port

/* rtl/hpb_pkg.sv */
// Constants, types and timing for the burst-capable host port.
// Assumes the host pins are already synchronous to clk_i at 40 MHz.
package hpb_pkg;

  // ----------------------------------------------------------------
  // Widths and memory shape
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 11;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned MEM_DEPTH = 2048;

  typedef logic [ADDR_W-1:0] hpb_addr_t;
  typedef logic [DATA_W-1:0] hpb_data_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 25000;
  // Least settle time before ready/acknowledge reports stable data
  localparam int unsigned SETTLE_NS      = 50;
  localparam int unsigned SETTLE_CYC_RAW =
    (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SETTLE_CYC     = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
  localparam int unsigned CNT_W          = 4;
  localparam logic [CNT_W-1:0] SETTLE_LOAD = CNT_W'(SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE     = 4'h1;

  // ----------------------------------------------------------------
  // Address stepping and reset values
  // ----------------------------------------------------------------
  localparam hpb_addr_t ADDR_STEP  = 11'h001;
  localparam hpb_addr_t ADDR_RESET = 11'h000;
  localparam hpb_data_t DATA_RESET = 8'h00;
  localparam logic      STYLE_A    = 1'b0;   // Strap low: latch-enable host style
  localparam logic      STYLE_B    = 1'b1;   // Strap high: address-strobe host style

  // ----------------------------------------------------------------
  // Host pin bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic      cs_n;                          // Chip select, active low
    logic      address_latch_strobe;          // Latch enable / address strobe
    logic      read_or_data_strobe_n;         // Read strobe / data strobe
    logic      write_or_rw_n;                 // Write strobe / read-not-write
    hpb_addr_t addr;
    hpb_data_t data;
  } hpb_pins_t;

  localparam hpb_pins_t PINS_IDLE = '{
    cs_n: 1'b1, address_latch_strobe: 1'b0, read_or_data_strobe_n: 1'b1,
    write_or_rw_n: 1'b1, addr: 11'h000, data: 8'h00};

  // Data-strobe cycle progress
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_SETTLE,
    ACC_HOLD
  } hpb_acc_t;

endpackage : hpb_pkg
